//--- core/sbtc_pkg.sv
/*
 * Shared constants for the sixteen-bit timer/counter: register indices
 * and byte addresses, control field positions, reset values, trigger
 * code and AXI4-Lite response codes.
 * Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
 */
package sbtc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned SBTC_ADDR_W = 12;
    localparam int unsigned SBTC_DATA_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] SBTC_IDX_FLAGS = 12'h00c;
    localparam logic [11:0] SBTC_IDX_CNT_LO = 12'h00e;
    localparam logic [11:0] SBTC_IDX_CNT_HI = 12'h00f;
    localparam logic [11:0] SBTC_IDX_CTRL = 12'h010;
    localparam logic [11:0] SBTC_IDX_ENABLES = 12'h08c;
    localparam logic [11:0] SBTC_ADDR_FLAGS = SBTC_IDX_FLAGS << 2;
    localparam logic [11:0] SBTC_ADDR_CNT_LO = SBTC_IDX_CNT_LO << 2;
    localparam logic [11:0] SBTC_ADDR_CNT_HI = SBTC_IDX_CNT_HI << 2;
    localparam logic [11:0] SBTC_ADDR_CTRL = SBTC_IDX_CTRL << 2;
    localparam logic [11:0] SBTC_ADDR_ENABLES = SBTC_IDX_ENABLES << 2;

    // One-hot register select positions
    localparam int unsigned SBTC_SEL_FLAGS = 0;
    localparam int unsigned SBTC_SEL_CNT_LO = 1;
    localparam int unsigned SBTC_SEL_CNT_HI = 2;
    localparam int unsigned SBTC_SEL_CTRL = 3;
    localparam int unsigned SBTC_SEL_ENABLES = 4;
    localparam int unsigned SBTC_SEL_N = 5;

    ////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int unsigned SBTC_CTRL_RUN = 0;
    localparam int unsigned SBTC_CTRL_CS = 1;
    localparam int unsigned SBTC_CTRL_SYNC_DIS = 2;
    localparam int unsigned SBTC_CTRL_OSC_EN = 3;
    localparam int unsigned SBTC_CTRL_PSC_LO = 4;
    localparam int unsigned SBTC_CTRL_PSC_HI = 5;
    localparam logic [7:0] SBTC_CTRL_MASK = 8'h3f;
    localparam logic [7:0] SBTC_CTRL_RST = 8'h00;

    // Flag and enable registers: overflow lives in bit 0
    localparam int unsigned SBTC_OVF_BIT = 0;
    localparam logic [7:0] SBTC_IRQ_RST = 8'h00;

    // Count values
    localparam logic [15:0] SBTC_CNT_ZERO = 16'h0000;
    localparam logic [15:0] SBTC_CNT_MAX = 16'hffff;
    localparam logic [2:0] SBTC_PSC_ZERO = 3'h0;

    // Compare mode code that issues the special event trigger
    localparam logic [3:0] SBTC_TRIG_CODE = 4'hb;

    // Instruction clock is the core clock divided by four
    localparam int unsigned SBTC_INSTR_DIV = 4;
    localparam logic [1:0] SBTC_INSTR_LAST = 2'(SBTC_INSTR_DIV - 1);
    localparam int unsigned SBTC_LP_OSC_MAX_KHZ = 200;
    localparam int unsigned SBTC_CLK_MHZ = 125;

    // AXI4-Lite responses
    localparam logic [1:0] SBTC_RESP_OKAY = 2'b00;
    localparam logic [1:0] SBTC_RESP_SLVERR = 2'b10;

    // Counter-mode arming: a falling edge must precede counting
    typedef enum logic [2:0] {
        SBTC_ARM_OFF = 3'b001,
        SBTC_ARM_WAIT_FALL = 3'b010,
        SBTC_ARM_ARMED = 3'b100
    } sbtc_arm_t;

endpackage

//--- core/sbtc_timer.sv
/*
 * Sixteen-bit timer/counter with prescaler, external pin counting,
 * sleep behaviour, compare-trigger clear and an AXI4-Lite register file.
 * Assumes one clock (aclk) with a synchronous active-low reset that acts
 * as the power-on reset; pins arrive asynchronously; sleep and compare
 * events come from logic on aclk.
 */
// Contract
// - Source select clear counts the instruction clock; sync bit ignored.
// - External counting on rising edges, only after a first falling edge.
// - External source is crystal pin if oscillator enabled, else count pin.
// - Synchronised mode resynchronises after the prescaler, a ripple divider; here the prescaler is a counter on aclk.
// - Synchronised counter mode in sleep: counter holds, prescaler counts.
// - Unsynchronised mode runs in sleep; enabled overflow wakes the core.
// - Unsynchronised count is not a valid capture or compare time base.
// - Count byte reads always return a coherent value.
// - Control bit 3 enables the low-power oscillator, kept in sleep.
// - Compare trigger with mode code 1011 clears the count to zero.
// - Trigger-driven clear never sets the overflow flag.
// - Trigger clear works in timer and synchronised counter modes.
// - A count write in the trigger cycle wins over the clear.
// - Count bytes are not cleared by any reset.
// - Control clears to zero on power-on reset only.
// - Any count byte write clears the prescaler.
// - Overflow flag and its enable sit in bit 0 of their registers.
// - Count wraps FFFFh to 0000h setting the flag; enable gates request.
// - Prescale field bits 5-4 select 1:1, 1:2, 1:4 or 1:8.
// - Control bit 2 set disables synchronisation, external source only.
`timescale 1ns/1ps

module sbtc_timer
    import sbtc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_count_pin,
    input wire logic crystal_input_pin,
    input wire logic sleep_mode,
    input wire logic compare_unit_a_event,
    input wire logic [3:0] compare_unit_a_mode,
    input wire logic compare_unit_b_event,
    input wire logic [3:0] compare_unit_b_mode,
    output logic [15:0] count_value,
    output logic time_base_valid,
    output logic low_power_osc_enable,
    output logic overflow_irq
);

    ////////////////////////////////////////////////////////////////////
    // Address decode shared by the read and write paths
    function automatic logic [SBTC_SEL_N-1:0] reg_sel(
        input logic [11:0] addr
    );
        logic [11:0] a;
        a = {addr[11:2], 2'b00};
        reg_sel = '0;
        reg_sel[SBTC_SEL_FLAGS] = (a == SBTC_ADDR_FLAGS);
        reg_sel[SBTC_SEL_CNT_LO] = (a == SBTC_ADDR_CNT_LO);
        reg_sel[SBTC_SEL_CNT_HI] = (a == SBTC_ADDR_CNT_HI);
        reg_sel[SBTC_SEL_CTRL] = (a == SBTC_ADDR_CTRL);
        reg_sel[SBTC_SEL_ENABLES] = (a == SBTC_ADDR_ENABLES);
    endfunction

    // Last prescaler count before an output tick
    function automatic logic [2:0] psc_last(input logic [1:0] sel);
        case (sel)
            2'b00: psc_last = 3'h0;
            2'b01: psc_last = 3'h1;
            2'b10: psc_last = 3'h3;
            default: psc_last = 3'h7;
        endcase
    endfunction

    logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_fire;
    logic [SBTC_SEL_N-1:0] wr_sel, rd_sel;
    logic wr_flags, wr_lo, wr_hi, wr_ctrl, wr_en, cnt_wr;
    logic [7:0] ctrl_reg, en_reg;
    logic flag_reg, flag_next;
    logic [15:0] count_reg, count_next;
    logic [2:0] psc_reg;
    logic [1:0] div_reg;
    logic [2:0] ext_sync_reg, osc_sync_reg;
    logic ext_lvl_reg, osc_lvl_reg, src_lvl_prev_reg;
    logic sync_stage_reg, irq_reg;
    sbtc_arm_t arm_reg;
    logic run, cs, sync_dis, async_mode, src_lvl, rise, fall;
    logic instr_tick, src_tick, psc_out, inc, trig, trig_ok, ovf_evt;

    assign run = ctrl_reg[SBTC_CTRL_RUN];
    assign cs = ctrl_reg[SBTC_CTRL_CS];
    assign sync_dis = ctrl_reg[SBTC_CTRL_SYNC_DIS];
    // sync bit only matters with external source
    assign async_mode = cs & sync_dis;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_sel = reg_sel(aw_addr_reg);
    assign wr_en = wr_fire && w_strb_reg[0];
    assign wr_flags = wr_en && wr_sel[SBTC_SEL_FLAGS];
    assign wr_lo = wr_en && wr_sel[SBTC_SEL_CNT_LO];
    assign wr_hi = wr_en && wr_sel[SBTC_SEL_CNT_HI];
    assign wr_ctrl = wr_en && wr_sel[SBTC_SEL_CTRL];
    assign cnt_wr = wr_lo || wr_hi;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= SBTC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (|wr_sel) ? SBTC_RESP_OKAY : SBTC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read: data one cycle after the address is taken
    assign s_axi_arready = !rvalid_reg;
    assign rd_sel = reg_sel(s_axi_araddr);

    // count is one aclk register, so reads are coherent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= SBTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= (|rd_sel) ? SBTC_RESP_OKAY : SBTC_RESP_SLVERR;
            rdata_reg <= '0;
            if (rd_sel[SBTC_SEL_FLAGS])
                rdata_reg[SBTC_OVF_BIT] <= flag_reg;
            if (rd_sel[SBTC_SEL_CNT_LO])
                rdata_reg[7:0] <= count_reg[7:0];
            if (rd_sel[SBTC_SEL_CNT_HI])
                rdata_reg[7:0] <= count_reg[15:8];
            if (rd_sel[SBTC_SEL_CTRL])
                rdata_reg[7:0] <= ctrl_reg;
            if (rd_sel[SBTC_SEL_ENABLES])
                rdata_reg[7:0] <= en_reg;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////
    // Control and enable registers
    // aresetn stands for power-on; control clears to zero
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ctrl_reg <= SBTC_CTRL_RST;
        else if (wr_ctrl)
            ctrl_reg <= w_data_reg[7:0] & SBTC_CTRL_MASK;
    end

    // all eight enable bits are stored and read back; only bit 0, the overflow enable, is used
    always_ff @(posedge aclk) begin
        if (!aresetn)
            en_reg <= SBTC_IRQ_RST;
        else if (wr_en && wr_sel[SBTC_SEL_ENABLES])
            en_reg <= w_data_reg[7:0];
    end

    // oscillator enable drives the crystal amplifier
    assign low_power_osc_enable = ctrl_reg[SBTC_CTRL_OSC_EN];
    assign time_base_valid = !async_mode;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge aclk) begin
        ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin};
        osc_sync_reg <= {osc_sync_reg[1:0], crystal_input_pin};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_lvl_reg <= 1'b0;
            osc_lvl_reg <= 1'b0;
        end else begin
            if (ext_sync_reg[1] == ext_sync_reg[2])
                ext_lvl_reg <= ext_sync_reg[2];
            if (osc_sync_reg[1] == osc_sync_reg[2])
                osc_lvl_reg <= osc_sync_reg[2];
        end
    end

    // oscillator enable picks the crystal input
    assign src_lvl = ctrl_reg[SBTC_CTRL_OSC_EN] ? osc_lvl_reg : ext_lvl_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            src_lvl_prev_reg <= 1'b0;
        else
            src_lvl_prev_reg <= src_lvl;
    end
    assign rise = src_lvl && !src_lvl_prev_reg;
    assign fall = !src_lvl && src_lvl_prev_reg;

    ////////////////////////////////////////////////////////////////////
    // arm only after a falling edge once enabled
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || !cs) begin
            arm_reg <= SBTC_ARM_OFF;
        end else begin
            case (arm_reg)
                SBTC_ARM_OFF: arm_reg <= SBTC_ARM_WAIT_FALL;
                SBTC_ARM_WAIT_FALL:
                    if (fall)
                        arm_reg <= SBTC_ARM_ARMED;
                SBTC_ARM_ARMED: arm_reg <= SBTC_ARM_ARMED;
                default: arm_reg <= SBTC_ARM_OFF;
            endcase
        end
    end

    // Instruction clock divider; stops in sleep like the core oscillator
    always_ff @(posedge aclk) begin
        if (!aresetn)
            div_reg <= '0;
        else if (!sleep_mode)
            div_reg <= (div_reg == SBTC_INSTR_LAST) ? 2'b00 : div_reg + 2'b01;
    end
    assign instr_tick = !sleep_mode && (div_reg == SBTC_INSTR_LAST);

    // timer mode counts instruction ticks, sync bit ignored
    assign src_tick = run && (cs ? (rise && arm_reg == SBTC_ARM_ARMED)
                                 : instr_tick);

    ////////////////////////////////////////////////////////////////////
    // Prescaler: modelled on aclk rather than as a true ripple divider
    // division ratio from the prescale field
    assign psc_out = src_tick &&
        (psc_reg == psc_last(ctrl_reg[SBTC_CTRL_PSC_HI:SBTC_CTRL_PSC_LO]));

    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_wr)
            psc_reg <= SBTC_PSC_ZERO;
        else if (psc_out)
            psc_reg <= SBTC_PSC_ZERO;
        else if (src_tick)
            psc_reg <= psc_reg + 3'h1;
    end

    // stage is shut off in sleep so the counter holds
    always_ff @(posedge aclk) begin
        if (!aresetn)
            sync_stage_reg <= 1'b0;
        else
            sync_stage_reg <= psc_out && cs && !sync_dis && !sleep_mode;
    end

    // unsynchronised path bypasses the stage and ignores sleep
    assign inc = cs ? (sync_dis ? psc_out : sync_stage_reg) : psc_out;

    ////////////////////////////////////////////////////////////////////
    // trigger from either compare unit in code 1011
    assign trig = (compare_unit_a_event &&
                   compare_unit_a_mode == SBTC_TRIG_CODE) ||
                  (compare_unit_b_event &&
                   compare_unit_b_mode == SBTC_TRIG_CODE);
    // trigger clear is withheld in unsynchronised mode
    assign trig_ok = trig && !async_mode;

    // writes first, then trigger, then increment
    always_comb begin
        count_next = count_reg;
        ovf_evt = 1'b0;
        if (cnt_wr) begin
            if (wr_lo)
                count_next[7:0] = w_data_reg[7:0];
            if (wr_hi)
                count_next[15:8] = w_data_reg[7:0];
        end else if (trig_ok) begin
            count_next = SBTC_CNT_ZERO;
        end else if (inc) begin
            // wrap to zero marks an overflow
            count_next = count_reg + 16'h0001;
            ovf_evt = (count_reg == SBTC_CNT_MAX);
        end
    end

    // count bytes have no reset term
    always_ff @(posedge aclk) begin
        count_reg <= count_next;
    end
    assign count_value = count_reg;

    // only a real wrap or a flag write of 1 sets the flag; set wins over clear
    always_comb begin
        flag_next = flag_reg;
        if (wr_flags)
            flag_next = w_data_reg[SBTC_OVF_BIT];
        if (ovf_evt)
            flag_next = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    // request only while enabled; also serves as sleep wake
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= flag_next && en_reg[SBTC_OVF_BIT];
    end
    assign overflow_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Count bytes power up unknown; the stopped-hold check waits until both are set
    logic [1:0] cnt_known_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cnt_known_reg <= 2'b00;
        else if (trig_ok && !cnt_wr)
            cnt_known_reg <= 2'b11;
        else
            cnt_known_reg <= cnt_known_reg | {wr_hi, wr_lo};
    end

    sequence s_wrap;
        inc && !cnt_wr && !trig_ok && count_reg == SBTC_CNT_MAX;
    endsequence
    sequence s_trig_alone;
        trig_ok && !cnt_wr && !wr_flags && !flag_reg;
    endsequence

    a_wrap_sets_flag: assert property (
        s_wrap |=> flag_reg && count_reg == SBTC_CNT_ZERO
    ) else $error("wrap did not set flag and zero count");

    a_trig_clears_count: assert property (
        trig_ok && !cnt_wr |=> count_reg == SBTC_CNT_ZERO
    ) else $error("trigger did not clear count");

    a_trig_no_flag: assert property (
        s_trig_alone |=> !flag_reg
    ) else $error("trigger clear set overflow flag");

    a_write_beats_trig: assert property (
        wr_lo && trig |=> count_reg[7:0] == $past(w_data_reg[7:0])
    ) else $error("trigger overrode count write");

    a_write_clears_psc: assert property (
        cnt_wr |=> psc_reg == SBTC_PSC_ZERO
    ) else $error("prescaler not cleared by count write");

    a_stopped_holds: assert property (
        !run && !cnt_wr && !trig_ok && !sync_stage_reg && &cnt_known_reg
        |=> count_reg == $past(count_reg)
    ) else $error("stopped counter moved");

    a_sleep_sync_hold: assert property (
        cs && !sync_dis && sleep_mode && !cnt_wr && !trig_ok
        && !sync_stage_reg ##1 sleep_mode && !cnt_wr && !trig_ok
        |=> $stable(count_reg)
    ) else $error("synchronised count moved in sleep");

    a_unarmed_no_tick: assert property (
        cs && arm_reg != SBTC_ARM_ARMED |-> !src_tick
    ) else $error("counted before first falling edge");

    a_ctrl_after_reset: assert property (
        $rose(aresetn) |-> ctrl_reg == SBTC_CTRL_RST
    ) else $error("control not cleared by reset");

    a_async_sleep_runs: assert property (
        async_mode && psc_out && !cnt_wr && count_reg != SBTC_CNT_MAX
        |=> count_reg == $past(count_reg) + 16'h0001
    ) else $error("unsynchronised count missed an edge");

endmodule

//--- bench/sbtc_pulse_src.sv
/*
 * Far-side model: an external pulse source or crystal on the count pins.
 * Assumes bursts are requested one at a time, on aclk.
 */
`timescale 1ns/1ps
module sbtc_pulse_src
    import sbtc_pkg::*;
(
    input wire logic aclk,
    input wire logic go,
    input wire logic osc_sel,
    input wire logic [7:0] pulses,
    input wire logic [3:0] half,
    output logic external_count_pin,
    output logic crystal_input_pin,
    output logic busy
);
////////////////////////////////////////////////////////////
logic [8:0] left = 9'h000;
logic [3:0] tick = 4'h0;
logic level = 1'b0;
logic [2:0] noise = 3'h0;

always_ff @(posedge aclk) begin
    noise <= noise + 3'h1;
    if (go) begin
        level <= 1'b1;
        left <= {pulses, 1'b0} - 9'h1;
        tick <= half;
    end else if (left != 9'h000) begin
        if (tick == 4'h1) begin
            level <= ~level;
            left <= left - 9'h1;
            tick <= half;
        end else begin
            tick <= tick - 4'h1;
        end
    end
end

// Unselected pin moves, so a wrong pin choice shows up as counts
assign external_count_pin = osc_sel ? noise[2] : level;
assign crystal_input_pin = osc_sel ? level : noise[2];
assign busy = left != 9'h000;
endmodule

//--- bench/testbench.sv
/*
 * Self-checking bench for the timer/counter.
 * Assumes the pulse source model and AXI4-Lite register access.
 */
`timescale 1ns/1ps
module testbench
    import sbtc_pkg::*;
;
logic aclk = 1'b0, aresetn = 1'b0, sleep = 1'b0, go = 1'b0, osc = 1'b0;
logic awv = 1'b0, wv = 1'b0, arv = 1'b0, ev_a = 1'b0, ev_b = 1'b0;
logic [11:0] awa = 12'h000, ara = 12'h000;
logic [31:0] wd = 32'h0, rdv, rd_d;
logic [7:0] npl = 8'h00;
logic [3:0] hlf = 4'h6, mode = 4'h0;
logic awr, w_rdy, bv, arr, rv, tbv, lpo, irq, epin, xpin, busy, seen;
logic [1:0] br, rr, rsp;
logic [15:0] cnt, c0, v;
int error_cnt = 0, checks = 0, m, n;

sbtc_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(w_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .external_count_pin(epin), .crystal_input_pin(xpin),
    .sleep_mode(sleep), .compare_unit_a_event(ev_a),
    .compare_unit_a_mode(mode), .compare_unit_b_event(ev_b),
    .compare_unit_b_mode(mode), .count_value(cnt),
    .time_base_valid(tbv), .low_power_osc_enable(lpo),
    .overflow_irq(irq)
);
sbtc_pulse_src u_src (
    .aclk(aclk), .go(go), .osc_sel(osc), .pulses(npl), .half(hlf),
    .external_count_pin(epin), .crystal_input_pin(xpin), .busy(busy)
);

////////////////////////////////////////////////////////////
// Clock, bus tasks and bookkeeping
initial begin
    forever #4 aclk = ~aclk;
end

task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (w_rdy) wv <= 1'b0;
        if (bv) break;
    end
    rsp = br;
endtask

task automatic rd(input logic [11:0] a);
    ara <= a;
    arv <= 1'b1;
    forever begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
        if (rv) break;
    end
    rdv = rd_d;
    rsp = rr;
endtask

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
endtask

// Burst of pulses, then wait out the synchroniser latency
task automatic burst(input int k);
    hlf <= 4'($urandom_range(12, 6));
    npl <= 8'(k);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (10) @(posedge aclk);
endtask

task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask

initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    close_out();
end

////////////////////////////////////////////////////////////
initial begin
    void'($urandom(32'h643ca995));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SBTC_ADDR_CTRL);
    chk("ctrl_reset", 32'h0, rdv);
    rd(SBTC_ADDR_ENABLES);
    chk("enable_reset", 32'h0, rdv);
    chk("osc_reset", 32'h0, lpo);
    wr(12'h004, 8'h01);
    chk("wr_unmapped", SBTC_RESP_SLVERR, rsp);
    rd(12'h004);
    chk("rd_unmapped", SBTC_RESP_SLVERR, rsp);
    $display("test registers done");
    // Timer rate over a whole number of prescaled ticks, sync bit random
    wr(SBTC_ADDR_CNT_LO, 8'($urandom));
    wr(SBTC_ADDR_CNT_HI, 8'($urandom));
    for (int p = 0; p < 4; p++) begin
        m = $urandom_range(12, 1);
        wr(SBTC_ADDR_CTRL, {2'b00, 2'(p), 1'b0, 1'($urandom), 2'b01});
        @(posedge aclk);
        c0 = cnt;
        repeat ((4 * m) << p) @(posedge aclk);
        chk("timer_rate", 16'(c0 + m), cnt);
    end
    v = 16'($urandom);
    wr(SBTC_ADDR_CTRL, 8'h30);
    wr(SBTC_ADDR_CNT_LO, v[7:0]);
    wr(SBTC_ADDR_CNT_HI, v[15:8]);
    repeat (40) @(posedge aclk);
    chk("stopped", v, cnt);
    rd(SBTC_ADDR_CNT_HI);
    chk("high_byte", v[15:8], rdv);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("count_kept", v, cnt);
    rd(SBTC_ADDR_CTRL);
    chk("ctrl_por", 32'h0, rdv);
    $display("test timer done");
    // Pin choice, sync choice and sleep; first rising edge is not counted
    for (int k = 0; k < 8; k++) begin
        n = $urandom_range(9, 3);
        osc <= k[0];
        // Oscillator enabled while stopped, given time to start
        wr(SBTC_ADDR_CTRL, {4'h0, k[0], 3'b000});
        repeat (8) @(posedge aclk);
        wr(SBTC_ADDR_CNT_LO, 8'h00);
        wr(SBTC_ADDR_CNT_HI, 8'h00);
        wr(SBTC_ADDR_CTRL, {4'h0, k[0], k[1], 2'b11});
        chk("osc_enable", k[0], lpo);
        chk("time_base", !k[1], tbv);
        sleep <= k[2];
        burst(n);
        chk("edges", (k[2] && !k[1]) ? 0 : n - 1, cnt);
        sleep <= 1'b0;
    end
    $display("test counter done");
    // Wrap with the request enabled, then masked
    for (int e = 0; e < 2; e++) begin
        wr(SBTC_ADDR_CTRL, 8'h00);
        wr(SBTC_ADDR_ENABLES, 8'(1 - e));
        wr(SBTC_ADDR_FLAGS, 8'h00);
        wr(SBTC_ADDR_CNT_HI, 8'hff);
        wr(SBTC_ADDR_CNT_LO, 8'hfd);
        wr(SBTC_ADDR_CTRL, 8'h01);
        seen = 1'b0;
        repeat (40) begin
            @(posedge aclk);
            seen |= irq;
        end
        rd(SBTC_ADDR_FLAGS);
        chk("ovf_flag", 32'h1, rdv);
        chk("ovf_irq", 1 - e, seen);
    end
    $display("test overflow done");
    // Both units, matching and non-matching mode code
    wr(SBTC_ADDR_FLAGS, 8'h00);
    for (int t = 0; t < 4; t++) begin
        wr(SBTC_ADDR_CNT_HI, 8'h12);
        mode <= t[1] ? 4'ha : SBTC_TRIG_CODE;
        ev_a <= !t[0];
        ev_b <= t[0];
        @(posedge aclk);
        ev_a <= 1'b0;
        ev_b <= 1'b0;
        @(posedge aclk);
        chk("trig_clear", t[1], cnt != 16'h0);
    end
    rd(SBTC_ADDR_FLAGS);
    chk("trig_no_flag", 32'h0, rdv);
    // Count write lands on the same edge as a trigger
    wr(SBTC_ADDR_CTRL, 8'h00);
    wr(SBTC_ADDR_CNT_HI, 8'h33);
    mode <= SBTC_TRIG_CODE;
    fork
        wr(SBTC_ADDR_CNT_LO, 8'h5a);
        begin
            @(posedge aclk);
            ev_b <= 1'b1;
            @(posedge aclk);
            ev_b <= 1'b0;
        end
    join
    chk("write_wins", 32'h335a, cnt);
    $display("test trigger done");
    close_out();
end
endmodule
